// ### rtl/tocd_pkg.sv
package tocd_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  // measuring window for the divided link clock monitor, in microseconds
  localparam int WIN_US = 50;
  localparam int WIN_CYCLES = WIN_US * (CLK_HZ / 1_000_000);
  // thresholds of the divided monitor clock, in kHz
  localparam int OPEN_FREQ_KHZ = 100;
  localparam int RAISE_FREQ_KHZ = 200;
  localparam int OPEN_EDGES = (OPEN_FREQ_KHZ * WIN_US) / 1000;
  localparam int RAISE_EDGES = (RAISE_FREQ_KHZ * WIN_US + 999) / 1000;
  localparam int CNT_W = 16;
  // sync stages plus one before the one-shot strap capture
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {LVL_0, LVL_R, LVL_F, LVL_1} tocd_lvl_e;
  typedef enum logic [2:0] {TERM_NONE, TERM_P300, TERM_P100, TERM_V150, TERM_V50} tocd_term_e;

  localparam logic [1:0] IMP_NONE = 2'h0;
  localparam logic [1:0] IMP_P300 = 2'h1;
  localparam logic [1:0] IMP_AUTO = 2'h2;
  localparam logic [1:0] IMP_P100 = 2'h3;

  localparam logic [1:0] EMPH_PRE35 = 2'h0;
  localparam logic [1:0] EMPH_DE25 = 2'h1;
  localparam logic [1:0] EMPH_0DB = 2'h2;
  localparam logic [1:0] EMPH_PRE60 = 2'h3;

  localparam logic [3:0] SWG_MINUS5 = 4'h7;
  localparam logic [3:0] SWG_DEFAULT = 4'h8;
  localparam logic [3:0] SWG_PLUS5 = 4'h9;
  localparam logic [2:0] LIN_MAX = 3'h7;
  localparam logic [2:0] EDGE_NONE = 3'h0;
  localparam logic [2:0] EDGE_CLK_MAX = 3'h3;
  localparam logic [2:0] EDGE_LOW_MIN = 3'h2;
  localparam logic [2:0] EDGE_LOW_MAX = 3'h5;
  localparam logic [2:0] EDGE_HIGH_MIN = 3'h3;
  localparam logic [2:0] EDGE_HIGH_MAX = 3'h6;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TERM = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_EMPH = 8'h08;
  localparam logic [7:0] OFS_SWING = 8'h0C;
  localparam logic [7:0] OFS_LIN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // term: [0] coupling select, [2:1] impedance select, [3] legacy auto
  localparam int TERM_CPL_BIT = 0;
  localparam int TERM_IMP_LSB = 1;
  localparam int TERM_AUTO_BIT = 3;
  // edge: [2:0] clock lane, [6:4] low rate, [10:8] high rate
  localparam int EDGE_CLK_LSB = 0;
  localparam int EDGE_LOW_LSB = 4;
  localparam int EDGE_HIGH_LSB = 8;
  // swing: legacy lanes [15:0], gen2 lanes [31:16], nibble per lane (clk,d0,d1,d2)
  localparam int SWG_GEN2_LSB = 16;

  localparam logic [31:0] TERM_RST = 32'h0000_0004;
  localparam logic [31:0] EDGE_RST = 32'h0000_0000;
  localparam logic [31:0] EMPH_RST = 32'h0000_0002;
  localparam logic [31:0] SWING_RST = 32'h8888_8888;
  localparam logic [31:0] LIN_RST = 32'h0000_0007;

endpackage : tocd_pkg

// ### rtl/tocd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tocd_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : tocd_sync
`default_nettype wire

// ### rtl/tocd_freq_mon.sv
`timescale 1ns/1ps
`default_nettype none
module tocd_freq_mon (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic mon,
  output logic term_on,
  output logic [tocd_pkg::CNT_W-1:0] last_edges
);
  import tocd_pkg::*;

  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYCLES - 1);
  localparam logic [CNT_W-1:0] OPEN_CNT = CNT_W'(OPEN_EDGES);
  localparam logic [CNT_W-1:0] RAISE_CNT = CNT_W'(RAISE_EDGES);

  logic mon_d;
  logic [CNT_W-1:0] win_cnt;
  logic [CNT_W-1:0] edge_cnt;
  logic rise;
  logic win_end;

  assign rise = mon & ~mon_d;
  assign win_end = (win_cnt == WIN_LAST);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mon_d <= 1'b0;
      win_cnt <= '0;
      edge_cnt <= '0;
      last_edges <= '0;
    end else begin
      mon_d <= mon;
      win_cnt <= win_end ? '0 : win_cnt + 1'b1;
      if (win_end) begin
        edge_cnt <= '0;
        last_edges <= edge_cnt + CNT_W'(rise);
      end else if (rise) begin
        edge_cnt <= edge_cnt + 1'b1;
      end
    end
  end

  // hysteresis: between the thresholds the previous choice holds
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      term_on <= 1'b0;
    end else if (win_end) begin
      if (edge_cnt + CNT_W'(rise) > RAISE_CNT) begin
        term_on <= 1'b1; // R3
      end else if (edge_cnt + CNT_W'(rise) < OPEN_CNT) begin
        term_on <= 1'b0; // R3
      end
    end
  end
endmodule : tocd_freq_mon
`default_nettype wire

// ### rtl/tocd_top.sv
// Functional notes
// R1: pin-strap termination follows bias and generation: 300/none, 100, 150, 50 ohm.
// R2: legacy external bias: strap high forces 300 ohm, low selects by frequency.
// R3: automatic legacy: open below low threshold, 300 ohm above high threshold.
// R4: register mode dc: select 00 none, 01 300, 11 100, 10 automatic.
// R5: auto dc: gen2 100 ohm; legacy 300 if auto field set, else by frequency.
// R6: register mode ac: 00/01 150, 11 50, 10 legacy 150 else 50.
// R7: edge rate from registers only in register mode and limited mode.
// R8: software programs only supported edge-rate codes per lane and generation.
// R9: emphasis on data lanes only, honoured only in limited mode.
// R10: pin-strap emphasis: 0 3.5dB, R -2.5dB, F 0dB, 1 6.0dB.
// R11: register mode swing set per lane, clock and data alike.
// R12: register mode uses legacy swing field in legacy, gen2 field in gen2.
// R13: pin-strap limited trims 1000 mV; gen2 clock lane stays default.
// R14: swing strap: R minus 5%, 0/F default, 1 plus 5% in gen2 only.
// R15: pin-strap linear fixes linearity at maximum; register mode uses a field.
// R16: bias choice from coupling strap or coupling register field.
// R17: first strap sampled continuously; coupling strap captured once.
// R18: generation and limited/linear inputs re-drive outputs whenever they change.
`timescale 1ns/1ps
`default_nettype none
module tocd_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [tocd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic register_mode,
  input wire logic gen2_mode,
  input wire logic linear_mode,
  input wire logic first_config_strap,
  input wire logic coupling_strap_pin,
  input wire logic [1:0] emphasis_strap_pin,
  input wire logic [1:0] swing_strap_pin,
  input wire logic link_clk_mon,
  output tocd_pkg::tocd_term_e term_sel,
  output logic edge_ctl_en,
  output logic [2:0] edge_clk,
  output logic [2:0] edge_data,
  output logic emph_en,
  output logic [1:0] emph_data,
  output logic [3:0] swing_clk,
  output logic [3:0] swing_data0,
  output logic [3:0] swing_data1,
  output logic [3:0] swing_data2,
  output logic [2:0] lin_range
);
  import tocd_pkg::*;

  // ----------------------------------------
  // strap inputs
  // ----------------------------------------
  logic cfg0_s;
  logic cpl_s;
  logic [1:0] emph_s;
  logic [1:0] swg_s;
  logic mon_s;
  logic [1:0] settle;
  logic strap_done;
  logic strap_cpl;
  tocd_lvl_e strap_emph;
  tocd_lvl_e strap_swg;
  logic auto_on;

  tocd_sync #(.W(7)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .din({first_config_strap, coupling_strap_pin, emphasis_strap_pin, swing_strap_pin, link_clk_mon}),
    .dout({cfg0_s, cpl_s, emph_s, swg_s, mon_s})
  );

  tocd_freq_mon u_freq (
    .ref_clk(ref_clk),
    .srst(srst),
    .mon(mon_s),
    .term_on(auto_on),
    .last_edges()
  );

  // one-shot capture once the synchronisers hold real pin levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      settle <= '0;
      strap_done <= 1'b0;
      strap_cpl <= 1'b0;
      strap_emph <= LVL_F;
      strap_swg <= LVL_0;
    end else if (!strap_done) begin
      settle <= settle + 1'b1;
      if (settle == STRAP_SETTLE) begin
        strap_done <= 1'b1;
        strap_cpl <= cpl_s; // R17
        strap_emph <= tocd_lvl_e'(emph_s);
        strap_swg <= tocd_lvl_e'(swg_s);
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [31:0] reg_term;
  logic [31:0] reg_edge;
  logic [31:0] reg_emph;
  logic [31:0] reg_swing;
  logic [31:0] reg_lin;
  logic [31:0] bmask;
  logic wr_go;
  logic [31:0] next_rdata;
  logic edge_bad;

  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_go = avs_write & ~avs_waitrequest;

  // one wait state: the access completes at the second edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_term <= TERM_RST;
      reg_edge <= EDGE_RST;
      reg_emph <= EMPH_RST;
      reg_swing <= SWING_RST;
      reg_lin <= LIN_RST;
    end else if (wr_go) begin
      unique case (avs_address)
        OFS_TERM: reg_term <= ((reg_term & ~bmask) | (avs_writedata & bmask)) & 32'h0000_000F;
        OFS_EDGE: reg_edge <= ((reg_edge & ~bmask) | (avs_writedata & bmask)) & 32'h0000_0777;
        OFS_EMPH: reg_emph <= ((reg_emph & ~bmask) | (avs_writedata & bmask)) & 32'h0000_0003;
        OFS_SWING: reg_swing <= (reg_swing & ~bmask) | (avs_writedata & bmask);
        OFS_LIN: reg_lin <= ((reg_lin & ~bmask) | (avs_writedata & bmask)) & 32'h0000_0007;
        default: ;
      endcase
    end
  end

  // unsupported codes only flagged; software is expected to avoid them
  always_comb begin
    edge_bad = reg_edge[EDGE_CLK_LSB +: 3] > EDGE_CLK_MAX; // R8
    if (gen2_mode) begin
      edge_bad = edge_bad | (reg_edge[EDGE_HIGH_LSB +: 3] < EDGE_HIGH_MIN) | (reg_edge[EDGE_HIGH_LSB +: 3] > EDGE_HIGH_MAX);
    end else begin
      edge_bad = edge_bad | (reg_edge[EDGE_LOW_LSB +: 3] < EDGE_LOW_MIN) | (reg_edge[EDGE_LOW_LSB +: 3] > EDGE_LOW_MAX);
    end
  end

  always_comb begin
    unique case (avs_address)
      OFS_TERM: next_rdata = reg_term;
      OFS_EDGE: next_rdata = reg_edge;
      OFS_EMPH: next_rdata = reg_emph;
      OFS_SWING: next_rdata = reg_swing;
      OFS_LIN: next_rdata = reg_lin;
      OFS_STATUS: next_rdata = {22'h00_0000, edge_bad, auto_on, strap_done, strap_cpl, cfg0_s, term_sel, 2'h0};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic ac_sel;
  logic [1:0] imp;
  tocd_term_e next_term;
  logic [1:0] next_emph;
  logic [3:0] trim;
  logic [15:0] lanes;

  assign ac_sel = register_mode ? reg_term[TERM_CPL_BIT] : strap_cpl; // R16
  assign imp = reg_term[TERM_IMP_LSB +: 2];

  always_comb begin
    next_term = TERM_NONE;
    if (!register_mode) begin
      if (ac_sel) begin
        next_term = gen2_mode ? TERM_V50 : TERM_V150; // R1
      end else if (gen2_mode) begin
        next_term = TERM_P100; // R1
      end else if (cfg0_s || auto_on) begin
        next_term = TERM_P300; // R2 R3
      end
    end else if (!ac_sel) begin
      unique case (imp)
        IMP_NONE: next_term = TERM_NONE; // R4
        IMP_P300: next_term = TERM_P300; // R4
        IMP_P100: next_term = TERM_P100; // R4
        IMP_AUTO: begin
          if (gen2_mode) begin
            next_term = TERM_P100; // R5
          end else if (reg_term[TERM_AUTO_BIT] || auto_on) begin
            next_term = TERM_P300; // R5
          end
        end
      endcase
    end else begin
      unique case (imp)
        IMP_NONE, IMP_P300: next_term = TERM_V150; // R6
        IMP_P100: next_term = TERM_V50; // R6
        IMP_AUTO: next_term = gen2_mode ? TERM_V50 : TERM_V150; // R6
      endcase
    end
  end

  always_comb begin
    unique case (strap_emph)
      LVL_0: next_emph = EMPH_PRE35; // R10
      LVL_R: next_emph = EMPH_DE25; // R10
      LVL_F: next_emph = EMPH_0DB; // R10
      LVL_1: next_emph = EMPH_PRE60; // R10
    endcase
    unique case (strap_swg)
      LVL_R: trim = SWG_MINUS5; // R14
      LVL_0, LVL_F: trim = SWG_DEFAULT; // R14
      LVL_1: trim = gen2_mode ? SWG_PLUS5 : SWG_DEFAULT; // R14
    endcase
  end

  assign lanes = gen2_mode ? reg_swing[SWG_GEN2_LSB +: 16] : reg_swing[15:0]; // R12

  // outputs re-evaluated every cycle, so mode inputs take effect at the next edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      term_sel <= TERM_NONE;
    end else begin
      term_sel <= next_term; // R18
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      edge_ctl_en <= 1'b0;
      edge_clk <= EDGE_NONE;
      edge_data <= EDGE_NONE;
    end else if (register_mode && !linear_mode) begin
      edge_ctl_en <= 1'b1; // R7
      edge_clk <= reg_edge[EDGE_CLK_LSB +: 3];
      edge_data <= gen2_mode ? reg_edge[EDGE_HIGH_LSB +: 3] : reg_edge[EDGE_LOW_LSB +: 3];
    end else begin
      edge_ctl_en <= 1'b0; // R7
      edge_clk <= EDGE_NONE;
      edge_data <= EDGE_NONE;
    end
  end

  // no clock-lane emphasis port exists at all
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      emph_en <= 1'b0;
      emph_data <= EMPH_0DB;
    end else begin
      emph_en <= ~linear_mode; // R9
      emph_data <= linear_mode ? EMPH_0DB : (register_mode ? reg_emph[1:0] : next_emph); // R9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      swing_clk <= SWG_DEFAULT;
      swing_data0 <= SWG_DEFAULT;
      swing_data1 <= SWG_DEFAULT;
      swing_data2 <= SWG_DEFAULT;
      lin_range <= LIN_MAX;
    end else if (register_mode) begin
      swing_clk <= lanes[3:0]; // R11
      swing_data0 <= lanes[7:4];
      swing_data1 <= lanes[11:8];
      swing_data2 <= lanes[15:12];
      lin_range <= reg_lin[2:0]; // R15
    end else if (linear_mode) begin
      swing_clk <= SWG_DEFAULT; // R15
      swing_data0 <= SWG_DEFAULT;
      swing_data1 <= SWG_DEFAULT;
      swing_data2 <= SWG_DEFAULT;
      lin_range <= LIN_MAX;
    end else begin
      swing_clk <= gen2_mode ? SWG_DEFAULT : trim; // R13
      swing_data0 <= trim;
      swing_data1 <= trim;
      swing_data2 <= trim;
      lin_range <= LIN_MAX;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  pin_ac_term_a: assert property (@(posedge ref_clk) disable iff (srst) // R1
    !register_mode && strap_cpl && gen2_mode |=> term_sel == TERM_V50)
    else $error("pin-strap ac gen2 termination not 50 ohm");
  strap_force_a: assert property (@(posedge ref_clk) disable iff (srst) // R2
    !register_mode && !strap_cpl && !gen2_mode && cfg0_s |=> term_sel == TERM_P300)
    else $error("high strap did not force 300 ohm");
  auto_open_a: assert property (@(posedge ref_clk) disable iff (srst) // R3
    !register_mode && !strap_cpl && !gen2_mode && !cfg0_s && !auto_on |=> term_sel == TERM_NONE)
    else $error("low link clock left termination on");
  imp_none_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
    register_mode && !reg_term[TERM_CPL_BIT] && imp == IMP_NONE |=> term_sel == TERM_NONE)
    else $error("impedance select 00 not open");
  auto_gen2_a: assert property (@(posedge ref_clk) disable iff (srst) // R5
    register_mode && !reg_term[TERM_CPL_BIT] && imp == IMP_AUTO && gen2_mode |=> term_sel == TERM_P100)
    else $error("automatic gen2 not 100 ohm");
  ac_auto_a: assert property (@(posedge ref_clk) disable iff (srst) // R6
    register_mode && reg_term[TERM_CPL_BIT] && imp == IMP_AUTO && !gen2_mode |=> term_sel == TERM_V150)
    else $error("ac automatic legacy not 150 ohm");
  edge_gate_a: assert property (@(posedge ref_clk) disable iff (srst) // R7
    !register_mode || linear_mode |=> !edge_ctl_en && edge_clk == EDGE_NONE && edge_data == EDGE_NONE)
    else $error("edge rate active outside register limited mode");
  emph_linear_a: assert property (@(posedge ref_clk) disable iff (srst) // R9
    linear_mode |=> !emph_en && emph_data == EMPH_0DB)
    else $error("emphasis applied in linear mode");
  emph_strap_a: assert property (@(posedge ref_clk) disable iff (srst) // R10
    !register_mode && !linear_mode && strap_emph == LVL_1 |=> emph_data == EMPH_PRE60)
    else $error("strap level 1 not 6 dB");
  swing_lane_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
    register_mode && gen2_mode |=> swing_data2 == $past(reg_swing[31:28]))
    else $error("gen2 swing field not used");
  clk_default_a: assert property (@(posedge ref_clk) disable iff (srst) // R13
    !register_mode && !linear_mode && gen2_mode && strap_swg == LVL_1 |=> swing_clk == SWG_DEFAULT && swing_data0 == SWG_PLUS5)
    else $error("gen2 strap swing wrong on clock or data");
  linear_fix_a: assert property (@(posedge ref_clk) disable iff (srst) // R15
    !register_mode && linear_mode |=> lin_range == LIN_MAX && swing_data1 == SWG_DEFAULT)
    else $error("pin-strap linear range not fixed");
  strap_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // R17
    strap_done |=> $stable(strap_cpl) && $stable(strap_emph))
    else $error("captured strap changed");
  bus_answer_a: assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait state");
endmodule : tocd_top
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tocd_pkg::*;
  logic ref_clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic register_mode, gen2_mode, linear_mode, first_config_strap, coupling_strap_pin, link_clk_mon, mon_run;
  logic [1:0] emphasis_strap_pin, swing_strap_pin, emph_data;
  tocd_term_e term_sel;
  logic edge_ctl_en, emph_en;
  logic [2:0] edge_clk, edge_data, lin_range, div;
  logic [3:0] swing_clk, swing_data0, swing_data1, swing_data2;
  logic [7:0] ofs [5] = '{OFS_TERM, OFS_EDGE, OFS_EMPH, OFS_SWING, OFS_LIN};
  logic [31:0] rv [5] = '{TERM_RST, EDGE_RST, EMPH_RST, SWING_RST, LIN_RST};
  int err_total, num_checks;

  tocd_top i_tocd_top (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .register_mode(register_mode),
    .gen2_mode(gen2_mode), .linear_mode(linear_mode), .first_config_strap(first_config_strap),
    .coupling_strap_pin(coupling_strap_pin), .emphasis_strap_pin(emphasis_strap_pin),
    .swing_strap_pin(swing_strap_pin), .link_clk_mon(link_clk_mon), .term_sel(term_sel),
    .edge_ctl_en(edge_ctl_en), .edge_clk(edge_clk), .edge_data(edge_data), .emph_en(emph_en),
    .emph_data(emph_data), .swing_clk(swing_clk), .swing_data0(swing_data0), .swing_data1(swing_data1),
    .swing_data2(swing_data2), .lin_range(lin_range));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // divided link clock, 100 edges per window
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!mon_run) begin
      div <= 3'h0;
      link_clk_mon <= 1'b0;
    end else if (div == 3'h4) begin
      div <= 3'h0;
      link_clk_mon <= ~link_clk_mon;
    end else begin
      div <= div + 3'h1;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic tchk(input tocd_term_e e);
    check("term_sel", {29'h0, e}, {29'h0, term_sel});
  endtask : tchk

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  // coupling, emphasis and swing straps are captured once, so a new value of those needs a reset; the first strap is sampled continuously
  task automatic rst();
    @(posedge ref_clk);
    srst <= 1'b1;
    cycles(6);
    srst <= 1'b0;
    cycles(8);
  endtask : rst

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    // only the watchdog ends a stalled access
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr32

  function automatic tocd_term_e exp_term(input logic cpl, input logic [1:0] imp, input logic g2);
    if (cpl)
      return (imp == IMP_P100 || (imp == IMP_AUTO && g2)) ? TERM_V50 : TERM_V150;
    if (imp == IMP_NONE)
      return TERM_NONE;
    if (imp == IMP_P300 || (imp == IMP_AUTO && !g2))
      return TERM_P300;
    return TERM_P100;
  endfunction : exp_term

  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    $display("unexpected watchdog: expected done seen running");
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {srst, avs_read, avs_write, register_mode, gen2_mode, linear_mode, mon_run} = 7'h40;
    {first_config_strap, coupling_strap_pin, emphasis_strap_pin, swing_strap_pin} = 6'h0;
    {avs_address, avs_byteenable, avs_writedata} = 44'h0;
    err_total = 0;
    num_checks = 0;
    for (int lv = 0; lv < 4; lv++) begin
      emphasis_strap_pin <= lv[1:0];
      swing_strap_pin <= lv[1:0];
      coupling_strap_pin <= lv[0];
      first_config_strap <= 1'b1;
      gen2_mode <= 1'b0;
      rst();
      check("emph_data", 32'(lv), 32'(emph_data));
      check("emph_en", 32'h1, 32'(emph_en));
      check("swing legacy", (lv == 1) ? 32'h7777 : 32'h8888, {16'h0, swing_data2, swing_data1, swing_data0, swing_clk});
      tchk(lv[0] ? TERM_V150 : TERM_P300);
      gen2_mode <= 1'b1;
      cycles(3);
      check("swing gen2 data", (lv == 1) ? 32'h7 : (lv == 3) ? 32'h9 : 32'h8, 32'(swing_data2));
      check("swing gen2 clk", 32'h8, 32'(swing_clk));
      tchk(lv[0] ? TERM_V50 : TERM_P100);
      linear_mode <= 1'b1;
      cycles(3);
      check("emph_en linear", 32'h0, 32'(emph_en));
      check("lin_range", 32'(LIN_MAX), 32'(lin_range));
      check("swing linear", 32'h8, 32'(swing_data1));
      linear_mode <= 1'b0;
    end
    coupling_strap_pin <= 1'b0;
    first_config_strap <= 1'b0;
    gen2_mode <= 1'b0;
    rst();
    tchk(TERM_NONE);
    first_config_strap <= 1'b1;
    cycles(4);
    tchk(TERM_P300);
    first_config_strap <= 1'b0;
    cycles(4);
    tchk(TERM_NONE);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 32'h0, 4'h0);
      check("reset value", rv[i], rd);
    end
    bus(1'b0, 8'h18, 32'h0, 4'h0);
    check("unmapped read", 32'h0, rd);
    wr32(OFS_EDGE, 32'h0000_0532);
    cycles(3);
    check("edge_ctl_en strap", 32'h0, 32'(edge_ctl_en));
    register_mode <= 1'b1;
    // ----------------------------------------
    // register mode
    // ----------------------------------------
    cycles(3);
    check("edge lanes", 32'h0000_0B22, {20'h0, edge_ctl_en, edge_data, 1'b0, edge_clk, 4'h2});
    gen2_mode <= 1'b1;
    cycles(3);
    check("edge data gen2", 32'h5, 32'(edge_data));
    wr32(OFS_LIN, 32'h3);
    linear_mode <= 1'b1;
    cycles(3);
    check("edge_ctl_en linear", 32'h0, 32'(edge_ctl_en));
    check("lin_range reg", 32'h3, 32'(lin_range));
    linear_mode <= 1'b0;
    wr32(OFS_EDGE, 32'h0000_0007);
    bus(1'b0, OFS_STATUS, 32'h0, 4'h0);
    check("status flag", 32'h200, rd & 32'hFFFF_FE03);
    for (int c = 0; c < 2; c++)
      for (int m = 0; m < 4; m++)
        for (int g = 0; g < 2; g++) begin
          gen2_mode <= g[0];
          wr32(OFS_TERM, {28'h0, 1'b1, m[1:0], c[0]});
          cycles(3);
          tchk(exp_term(c[0], m[1:0], g[0]));
        end
    wr32(OFS_SWING, 32'h1234_5678);
    gen2_mode <= 1'b0;
    cycles(3);
    check("swing reg legacy", 32'h5678, {16'h0, swing_data2, swing_data1, swing_data0, swing_clk});
    gen2_mode <= 1'b1;
    cycles(3);
    check("swing reg gen2", 32'h1234, {16'h0, swing_data2, swing_data1, swing_data0, swing_clk});
    bus(1'b1, OFS_SWING, 32'h0, 4'h1);
    bus(1'b0, OFS_SWING, 32'h0, 4'h0);
    check("byte lanes", 32'h1234_5600, rd);
    wr32(OFS_EMPH, 32'h3);
    cycles(3);
    check("emph reg", 32'h3, 32'(emph_data));
    // auto field clear: legacy termination follows the monitored clock
    gen2_mode <= 1'b0;
    wr32(OFS_TERM, 32'h4);
    cycles(3);
    tchk(TERM_NONE);
    mon_run <= 1'b1;
    cycles(2100);
    tchk(TERM_P300);
    mon_run <= 1'b0;
    cycles(2100);
    tchk(TERM_NONE);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
